// File: logic/fail_safe_clock_monitor_monitor.sv
/*
  Fail-safe clock monitor top: watches the primary clock, falls back to
  the internal clock on failure and handles start-up after reset/wake.
  Assumes primClk is synchronised to sys_clk, a plain register port, and
  that nrst is the power-on reset.
*/
// Added by the designer: the register offsets and the strobed register port.
`timescale 1ns/1ps
module fail_safe_clock_monitor_monitor #(
  parameter int OST_CYCLES = fail_safe_clock_monitor_pkg::OST_COUNT,
  parameter int PLL_CYCLES = fail_safe_clock_monitor_pkg::PLL_LOCK_CYC,
  parameter int WIN_CYCLES = fail_safe_clock_monitor_pkg::SAMPLE_WIN_CYC
) (
  input  wire logic                   sys_clk,
  input  wire logic                   nrst,
  input  wire logic [3:0]             regAddr,
  input  wire logic [7:0]             regWdata,
  input  wire logic                   regWr,
  input  wire logic                   regRd,
  output logic [7:0]                  regRdata,
  input  wire fail_safe_clock_monitor_pkg::fail_safe_clock_monitor_osc_mode_t oscMode,
  input  wire logic                   primClk,
  input  wire logic                   sleepReq,
  input  wire logic                   wakeEvt,
  input  wire logic                   anyIrq,
  output logic [1:0]                  clkSrcSel,
  output logic                        primEnable,
  output logic                        coreRun,
  output logic                        sampleFromRc,
  output logic                        irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_START, ST_WAIT_STABLE, ST_RUN, ST_FAILED, ST_SLEEP
  } fail_safe_clock_monitor_state_t;

  localparam int IRQ_W = fail_safe_clock_monitor_pkg::IRQ_WIDTH;

  fail_safe_clock_monitor_state_t      state_reg, state_next;
  logic [7:0]       clkSel_reg;
  logic [IRQ_W-1:0] irqStat_reg, irqMask_reg;
  logic             stable_reg;
  logic             stall_reg;
  logic             halted_reg;
  logic             primPrev_reg;

  wire        pmActive = clkSel_reg[fail_safe_clock_monitor_pkg::SEL_PM_BIT];
  wire        idleMode = clkSel_reg[fail_safe_clock_monitor_pkg::SEL_IDLE_BIT];
  wire [1:0]  selSrc   = clkSel_reg[fail_safe_clock_monitor_pkg::SEL_SRC_LSB +: 2];
  wire        isXtal   = (oscMode == fail_safe_clock_monitor_pkg::MODE_XTAL_STD) ||
                         (oscMode == fail_safe_clock_monitor_pkg::MODE_XTAL_LP)  ||
                         (oscMode == fail_safe_clock_monitor_pkg::MODE_XTAL_HS)  ||
                         (oscMode == fail_safe_clock_monitor_pkg::MODE_XTAL_HSMUL);
  wire        needPll  = (oscMode == fail_safe_clock_monitor_pkg::MODE_XTAL_HSMUL);
  wire        failIe   = irqMask_reg[fail_safe_clock_monitor_pkg::IRQ_FAIL_BIT];

  // ----------------------------------------------------------------
  // Primary edge detect
  // ----------------------------------------------------------------
  // Start-up timer counts primary rising edges, so a crystal that
  // never starts never ends the wait by timer and never looks failed.
  wire        primRise = primClk && !primPrev_reg;

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  wire wrSel  = regWr && (regAddr == fail_safe_clock_monitor_pkg::ADDR_CLK_SEL);
  wire wrStat = regWr && (regAddr == fail_safe_clock_monitor_pkg::ADDR_IRQ_STAT);
  wire wrMask = regWr && (regAddr == fail_safe_clock_monitor_pkg::ADDR_IRQ_MASK);
  wire [7:0] statusWord = {3'h0, halted_reg, stall_reg, stable_reg, clkSrcSel};
  wire [7:0] rdMux =
    (regAddr == fail_safe_clock_monitor_pkg::ADDR_CLK_SEL)  ? clkSel_reg :
    (regAddr == fail_safe_clock_monitor_pkg::ADDR_STATUS)   ? statusWord :
    (regAddr == fail_safe_clock_monitor_pkg::ADDR_IRQ_STAT) ? {6'h00, irqStat_reg} :
    (regAddr == fail_safe_clock_monitor_pkg::ADDR_IRQ_MASK) ? {6'h00, irqMask_reg} : 8'h00;

  // ----------------------------------------------------------------
  // Timers and activity watch
  // ----------------------------------------------------------------
  logic ostDone, pllDone, stalled;
  wire  enterWait = (state_reg != ST_WAIT_STABLE) && (state_next == ST_WAIT_STABLE);
  wire  waitAbort = (state_reg == ST_WAIT_STABLE) && (state_next != ST_WAIT_STABLE);
  // Watch runs only in the run state with the primary selected, never in start-up
  // wait, where slow crystals would look dead; this is why a crystal dead from start-up is never flagged.
  wire  watchOn   = (state_reg == ST_RUN) && (clkSrcSel == fail_safe_clock_monitor_pkg::SRC_PRIMARY);

  fail_safe_clock_monitor_timer #(.WIDTH(12)) u_ost (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .start   (enterWait),
    .clear   (waitAbort),
    .load    (12'(OST_CYCLES)),
    .tick    (primRise),
    .done    (ostDone)
  );

  fail_safe_clock_monitor_timer #(.WIDTH(20)) u_pll (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .start   (enterWait),
    .clear   (waitAbort),
    .load    (needPll ? 20'(PLL_CYCLES) : 20'h00001),
    .tick    (1'b1),
    .done    (pllDone)
  );

  fail_safe_clock_monitor_edge_watch #(.WINDOW(WIN_CYCLES)) u_watch (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .enable  (watchOn),
    .mon     (primClk),
    .stalled (stalled)
  );

  wire failEvt   = stalled && watchOn;
  wire stableEvt = (state_reg == ST_WAIT_STABLE) && ostDone && pllDone;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_START:       state_next = isXtal ? ST_WAIT_STABLE : ST_RUN;
      ST_WAIT_STABLE: begin
        if (sleepReq)
          state_next = ST_SLEEP;
        else if (pmActive && selSrc != fail_safe_clock_monitor_pkg::SRC_PRIMARY)
          state_next = ST_RUN;
        else if (stableEvt)
          state_next = ST_RUN;
      end
      ST_RUN: begin
        if (failEvt)
          state_next = ST_FAILED;
        else if (sleepReq)
          state_next = ST_SLEEP;
      end
      ST_FAILED:      state_next = ST_FAILED;
      ST_SLEEP:       if (wakeEvt) state_next = ST_START;
    endcase
  end

  // Source chosen for the next state
  // Restart after wake stays on internal until the crystal is proven
  wire [1:0] src_next =
    (state_next == ST_START)       ? 2'(fail_safe_clock_monitor_pkg::SRC_INTERNAL) :
    (state_next == ST_FAILED)      ? 2'(fail_safe_clock_monitor_pkg::SRC_INTERNAL) :
    (state_next == ST_WAIT_STABLE) ? 2'(fail_safe_clock_monitor_pkg::SRC_INTERNAL) :
    (pmActive)                     ? selSrc :
                                     2'(fail_safe_clock_monitor_pkg::SRC_PRIMARY);
  wire prim_next = (state_next != ST_SLEEP) && (state_next != ST_FAILED) &&
                   !(pmActive && selSrc != fail_safe_clock_monitor_pkg::SRC_PRIMARY);

  // Core halted after an Idle failure with interrupt off, until any interrupt
  wire halt_next = (failEvt && !failIe && idleMode) ? 1'b1 :
                   (anyIrq) ? 1'b0 : halted_reg;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg    <= ST_START;
      clkSel_reg   <= fail_safe_clock_monitor_pkg::CLK_SEL_RESET;
      irqStat_reg  <= '0;
      irqMask_reg  <= fail_safe_clock_monitor_pkg::IRQ_MASK_RESET;
      stable_reg   <= 1'b0;
      stall_reg    <= 1'b0;
      halted_reg   <= 1'b0;
      primPrev_reg <= 1'b0;
      clkSrcSel    <= 2'(fail_safe_clock_monitor_pkg::SRC_INTERNAL);
      primEnable   <= 1'b1;
      coreRun      <= 1'b0;
      sampleFromRc <= 1'b1;
      irq          <= 1'b0;
      regRdata     <= 8'h00;
    end else begin
      state_reg    <= state_next;
      if (wrSel)
        clkSel_reg <= regWdata;
      if (wrMask)
        irqMask_reg <= regWdata[IRQ_W-1:0];
      // Set wins over write-one-to-clear
      irqStat_reg  <= (irqStat_reg & ~(wrStat ? regWdata[IRQ_W-1:0] : '0)) |
                      {stableEvt, failEvt};
      stable_reg   <= (state_next == ST_RUN) && !(state_reg == ST_FAILED) &&
                      (stableEvt || stable_reg || !isXtal);
      stall_reg    <= stall_reg || failEvt;
      halted_reg   <= halt_next;
      primPrev_reg <= primClk;
      clkSrcSel    <= src_next;
      primEnable   <= prim_next;
      coreRun      <= (state_next != ST_SLEEP) && (state_next != ST_START) && !halt_next;
      sampleFromRc <= (state_next != ST_WAIT_STABLE);
      irq          <= |((irqStat_reg | {stableEvt, failEvt}) & irqMask_reg);
      regRdata     <= regRd ? rdMux : 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence failSeen_s;
    failEvt;
  endsequence

  sequence fallback_s;
    ##1 (clkSrcSel == 2'(fail_safe_clock_monitor_pkg::SRC_INTERNAL));
  endsequence

  fail_fallback_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    failSeen_s |-> fallback_s) else $error("no fallback after failure");

  no_return_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (state_reg == ST_FAILED) |=> (clkSrcSel == 2'(fail_safe_clock_monitor_pkg::SRC_INTERNAL))
  ) else $error("failed source reselected");

  fail_flag_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    failEvt |=> irqStat_reg[fail_safe_clock_monitor_pkg::IRQ_FAIL_BIT]) else $error("fail flag missing");

  no_wait_flag_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (state_reg == ST_WAIT_STABLE) |-> !failEvt) else $error("fail during start-up");

  xtal_internal_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (state_reg == ST_WAIT_STABLE && !pmActive) |=> (clkSrcSel == 2'(fail_safe_clock_monitor_pkg::SRC_INTERNAL) ||
      state_reg != ST_WAIT_STABLE)) else $error("crystal wait not on internal");

  direct_start_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (state_reg == ST_START && !isXtal) |=> (state_reg == ST_RUN))
    else $error("non-crystal start delayed");

  pm_select_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (state_reg == ST_RUN && pmActive && !failEvt && !sleepReq) |=> (clkSrcSel == $past(selSrc)))
    else $error("power-managed source not selected");

  alt_mode_off_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (state_reg == ST_WAIT_STABLE && pmActive && selSrc != fail_safe_clock_monitor_pkg::SRC_PRIMARY) |=> !primEnable)
    else $error("primary left on");

  idle_resume_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (halted_reg && anyIrq) |=> ##1 (coreRun || state_reg == ST_SLEEP))
    else $error("core not resumed");

  halt_set_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (failEvt && !failIe && idleMode) |=> (!coreRun && halted_reg))
    else $error("core not halted after idle failure");

  sequence wakeSeen_s;
    (state_reg == ST_SLEEP) && wakeEvt;
  endsequence

  sequence restart_s;
    ##1 (state_reg == ST_START && clkSrcSel == 2'(fail_safe_clock_monitor_pkg::SRC_INTERNAL))
    ##1 (state_reg == ST_WAIT_STABLE || state_reg == ST_RUN);
  endsequence

  wake_restart_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    wakeSeen_s |-> restart_s) else $error("wake restart wrong");

  dead_start_quiet_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (state_reg == ST_WAIT_STABLE && !irqStat_reg[fail_safe_clock_monitor_pkg::IRQ_FAIL_BIT]) |=>
      !irqStat_reg[fail_safe_clock_monitor_pkg::IRQ_FAIL_BIT]) else $error("fail flag during start-up");

  stable_flag_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    stableEvt |=> irqStat_reg[fail_safe_clock_monitor_pkg::IRQ_STABLE_BIT]) else $error("stable flag missing");

  stable_switch_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (stableEvt && !sleepReq && !pmActive) |=>
      (clkSrcSel == 2'(fail_safe_clock_monitor_pkg::SRC_PRIMARY) && sampleFromRc))
    else $error("no switch to stable crystal");

  clear_fail_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (wrStat && regWdata[fail_safe_clock_monitor_pkg::IRQ_FAIL_BIT] && !failEvt) |=>
      !irqStat_reg[fail_safe_clock_monitor_pkg::IRQ_FAIL_BIT]) else $error("fail flag not cleared");

  irq_on_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (|(irqStat_reg & irqMask_reg)) |=> irq) else $error("interrupt not raised");

  irq_off_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (!(|(irqStat_reg & irqMask_reg)) && !failEvt && !stableEvt) |=> !irq)
    else $error("interrupt raised while masked");

  read_data_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    regRd |=> (regRdata == $past(rdMux))) else $error("read data wrong");

  read_idle_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    !regRd |=> (regRdata == 8'h00)) else $error("read data without strobe");

endmodule

// File: logic/fail_safe_clock_monitor_pkg.sv
/*
  Package for the fail-safe clock monitor: register offsets, fields,
  reset values, mode encodings and timing counts.
  Assumes a single 125 MHz system clock domain.
*/
package fail_safe_clock_monitor_pkg;

  // ----------------------------------------------------------------
  // Primary oscillator modes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_EXT_CLOCK  = 3'h0,
    MODE_RC_OSC     = 3'h1,
    MODE_INT_RC     = 3'h2,
    MODE_XTAL_STD   = 3'h3,
    MODE_XTAL_LP    = 3'h4,
    MODE_XTAL_HS    = 3'h5,
    MODE_XTAL_HSMUL = 3'h6
  } fail_safe_clock_monitor_osc_mode_t;

  // Clock source selections
  typedef enum logic [1:0] {
    SRC_PRIMARY   = 2'h0,
    SRC_SECONDARY = 2'h1,
    SRC_INTERNAL  = 2'h2
  } fail_safe_clock_monitor_src_t;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_CLK_SEL  = 4'h0;
  localparam logic [3:0] ADDR_STATUS   = 4'h1;
  localparam logic [3:0] ADDR_IRQ_STAT = 4'h2;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h3;

  // Clock select fields
  localparam int SEL_SRC_LSB  = 0;
  localparam int SEL_IDLE_BIT = 2;
  localparam int SEL_PM_BIT   = 3;
  localparam logic [7:0] CLK_SEL_RESET = 8'h00;

  // Interrupt status bits
  localparam int IRQ_FAIL_BIT   = 0;
  localparam int IRQ_STABLE_BIT = 1;
  localparam int IRQ_WIDTH      = 2;
  localparam logic [IRQ_WIDTH-1:0] IRQ_MASK_RESET = 2'h0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 8;
  localparam int SAMPLE_WIN_NS   = 2000;
  localparam int SAMPLE_WIN_CYC  = SAMPLE_WIN_NS / CLK_PERIOD_NS;
  localparam int OST_COUNT       = 1024;
  localparam int PLL_LOCK_US     = 2000;
  localparam int PLL_LOCK_CYC    = (PLL_LOCK_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } fail_safe_clock_monitor_bus_t;

endpackage

// File: logic/fail_safe_clock_monitor_timer.sv
/*
  Down counter that asserts done once a load value has elapsed.
  Assumes start is a pulse; a new start restarts the count.
*/
`timescale 1ns/1ps
module fail_safe_clock_monitor_timer #(
  parameter int WIDTH = 20
) (
  input  wire logic             sys_clk,
  input  wire logic             nrst,
  input  wire logic             start,
  input  wire logic             clear,
  input  wire logic [WIDTH-1:0] load,
  input  wire logic             tick,
  output logic                  done
);

  logic [WIDTH-1:0] cnt_reg;
  logic             run_reg;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_reg <= '0;
      run_reg <= 1'b0;
      done    <= 1'b0;
    end else if (clear) begin
      run_reg <= 1'b0;
      done    <= 1'b0;
    end else if (start) begin
      cnt_reg <= load;
      run_reg <= 1'b1;
      done    <= 1'b0;
    end else if (run_reg && tick) begin
      if (cnt_reg <= WIDTH'(1)) begin
        run_reg <= 1'b0;
        done    <= 1'b1;
      end
      cnt_reg <= cnt_reg - WIDTH'(1);
    end
  end

endmodule

// File: logic/fail_safe_clock_monitor_edge_watch.sv
/*
  Activity watch: counts sample-clock cycles without a seen edge of the
  monitored clock and flags a stall once the window runs out.
  Assumes the monitored clock has been synchronised upstream.
*/
`timescale 1ns/1ps
module fail_safe_clock_monitor_edge_watch #(
  parameter int WINDOW = 250
) (
  input  wire logic sys_clk,
  input  wire logic nrst,
  input  wire logic enable,
  input  wire logic mon,
  output logic      stalled
);

  localparam int CW = $clog2(WINDOW + 1);

  logic [CW-1:0] idle_reg;
  logic          prev_reg;
  wire           edgeSeen = mon ^ prev_reg;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      idle_reg <= '0;
      prev_reg <= 1'b0;
      stalled  <= 1'b0;
    end else begin
      prev_reg <= mon;
      if (!enable || edgeSeen) begin
        idle_reg <= '0;
        stalled  <= 1'b0;
      end else if (idle_reg == CW'(WINDOW)) begin
        stalled  <= 1'b1;
      end else begin
        idle_reg <= idle_reg + CW'(1);
      end
    end
  end

endmodule

// File: tb/fail_safe_clock_monitor_osc_model.sv
/*
  Primary oscillator model: toggles primClk while enabled and alive.
  Assumes halfPer stays between 1 and 3 sys_clk cycles.
*/
`timescale 1ns/1ps
module fail_safe_clock_monitor_osc_model (
  input  wire logic       sys_clk,
  input  wire logic       enable,
  input  wire logic       alive,
  input  wire logic [1:0] halfPer,
  output logic            primClk
);
  int cnt;

  initial begin
    primClk = 1'b0;
    cnt     = 0;
  end

  // A dead crystal holds its level: no edges reach the monitor
  always @(posedge sys_clk) begin
    if (enable && alive) begin
      if (cnt + 1 >= halfPer) begin
        cnt     <= 0;
        primClk <= ~primClk;
      end else begin
        cnt <= cnt + 1;
      end
    end
  end
endmodule

// File: tb/fail_safe_clock_monitor_tb_top.sv
/*
  Self-checking bench for the clock monitor, short timer parameters.
  Assumes the register map and status layout of the package.
*/
`timescale 1ns/1ps
module fail_safe_clock_monitor_tb_top;
  logic                     sys_clk = 1'b0;
  logic                     nrst = 1'b0;
  logic [3:0]               regAddr = 4'h0;
  logic [7:0]               regWdata = 8'h00;
  logic                     regWr = 1'b0;
  logic                     regRd = 1'b0;
  logic [7:0]               regRdata;
  fail_safe_clock_monitor_pkg::fail_safe_clock_monitor_osc_mode_t oscMode = fail_safe_clock_monitor_pkg::MODE_EXT_CLOCK;
  logic                     primClk;
  logic                     sleepReq = 1'b0;
  logic                     wakeEvt = 1'b0;
  logic                     anyIrq = 1'b0;
  logic [1:0]               clkSrcSel;
  logic                     primEnable;
  logic                     coreRun;
  logic                     sampleFromRc;
  logic                     irq;
  logic                     oscAlive = 1'b1;
  logic [1:0]               halfPer = 2'h1;
  logic [31:0]              seed = 32'hB944CDCA;
  int                       n_mismatch = 0;
  int                       num_checks = 0;

  always #4 sys_clk = ~sys_clk;

  fail_safe_clock_monitor_monitor #(.OST_CYCLES(8), .PLL_CYCLES(8), .WIN_CYCLES(8)) i_fail_safe_clock_monitor_monitor (
    .sys_clk(sys_clk), .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .oscMode(oscMode),
    .primClk(primClk), .sleepReq(sleepReq), .wakeEvt(wakeEvt), .anyIrq(anyIrq),
    .clkSrcSel(clkSrcSel), .primEnable(primEnable), .coreRun(coreRun),
    .sampleFromRc(sampleFromRc), .irq(irq));

  fail_safe_clock_monitor_osc_model i_fail_safe_clock_monitor_osc_model (.sys_clk(sys_clk), .enable(primEnable),
    .alive(oscAlive), .halfPer(halfPer), .primClk(primClk));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  task automatic chk_out(input string nm, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask

  task automatic chk_rd(input logic [3:0] a, input logic [7:0] e, input string nm);
    @(posedge sys_clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1;
    chk_out(nm, e, regRdata);
  endtask

  task automatic wait_src(input logic [1:0] e, input int lim);
    int k;
    k = 0;
    while (clkSrcSel !== e && k < lim) begin
      @(posedge sys_clk);
      #1;
      k++;
    end
    chk_out("clkSrcSel", {6'h0, e}, {6'h0, clkSrcSel});
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic do_reset(input logic [2:0] m);
    @(posedge sys_clk);
    oscMode <= fail_safe_clock_monitor_pkg::fail_safe_clock_monitor_osc_mode_t'(m);
    nrst    <= 1'b0;
    seed = xs(seed);
    halfPer <= (seed[1:0] == 2'h0) ? 2'h1 : seed[1:0];
    cyc(2);
    chk_out("rstSrc", 8'h02, {6'h0, clkSrcSel});
    chk_out("rstIrq", 8'h00, {7'h0, irq});
    nrst <= 1'b1;
  endtask

  task automatic wrap_up();
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    cyc(20000);
    n_mismatch++;
    wrap_up();
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    for (int m = 0; m < 7; m++) begin
      do_reset(m[2:0]);
      cyc(2);
      chk_out("startSrc", (m < 3) ? 8'h00 : 8'h02, {6'h0, clkSrcSel});
      chk_out("rcWait", (m < 3) ? 8'h01 : 8'h00, {7'h0, sampleFromRc});
      wait_src(2'h0, 80);
      chk_out("rcSample", 8'h01, {7'h0, sampleFromRc});
      if (m >= 3) chk_rd(fail_safe_clock_monitor_pkg::ADDR_IRQ_STAT, 8'h02, "stableBit");
    end
    // Sleep and wake in crystal mode
    sleepReq <= 1'b1;
    cyc(1);
    sleepReq <= 1'b0;
    cyc(5);
    chk_out("sleepPrim", 8'h00, {7'h0, primEnable});
    chk_out("sleepRun", 8'h00, {7'h0, coreRun});
    wakeEvt <= 1'b1;
    cyc(1);
    wakeEvt <= 1'b0;
    cyc(1);
    chk_out("wakeSrc", 8'h02, {6'h0, clkSrcSel});
    wait_src(2'h0, 80);
    // Dead crystal: no failure, then a new mode drops the primary
    oscAlive <= 1'b0;
    do_reset(3'h5);
    cyc(40);
    chk_out("deadSrc", 8'h02, {6'h0, clkSrcSel});
    chk_rd(fail_safe_clock_monitor_pkg::ADDR_IRQ_STAT, 8'h00, "noFail");
    wr(fail_safe_clock_monitor_pkg::ADDR_CLK_SEL, 8'h09);
    cyc(3);
    chk_out("primOff", 8'h00, {7'h0, primEnable});
    chk_out("pmSrc", 8'h01, {6'h0, clkSrcSel});
    // Failure with interrupt enabled
    oscAlive <= 1'b1;
    do_reset(3'h0);
    chk_rd(fail_safe_clock_monitor_pkg::ADDR_IRQ_MASK, 8'h00, "maskRst");
    seed = xs(seed);
    chk_rd({2'h1, seed[1:0]} + 4'h4, 8'h00, "unmapped");
    wr(fail_safe_clock_monitor_pkg::ADDR_IRQ_MASK, 8'h03);
    chk_rd(fail_safe_clock_monitor_pkg::ADDR_IRQ_MASK, 8'h03, "maskRw");
    oscAlive <= 1'b0;
    wait_src(2'h2, 40);
    cyc(2);
    chk_out("irqFail", 8'h01, {7'h0, irq});
    chk_out("runFail", 8'h01, {7'h0, coreRun});
    chk_rd(fail_safe_clock_monitor_pkg::ADDR_STATUS, 8'h0A, "status");
    oscAlive <= 1'b1;
    cyc(30);
    chk_out("noReturn", 8'h02, {6'h0, clkSrcSel});
    wr(fail_safe_clock_monitor_pkg::ADDR_IRQ_STAT, 8'h01);
    cyc(3);
    chk_out("irqClr", 8'h00, {7'h0, irq});
    // Idle failure with interrupt disabled
    do_reset(3'h0);
    wr(fail_safe_clock_monitor_pkg::ADDR_CLK_SEL, 8'h04);
    oscAlive <= 1'b0;
    wait_src(2'h2, 40);
    cyc(2);
    chk_out("halted", 8'h00, {7'h0, coreRun});
    chk_out("irqMasked", 8'h00, {7'h0, irq});
    chk_rd(fail_safe_clock_monitor_pkg::ADDR_IRQ_STAT, 8'h01, "failFlag");
    anyIrq <= 1'b1;
    cyc(3);
    chk_out("resumed", 8'h01, {7'h0, coreRun});
    chk_out("resumeSrc", 8'h02, {6'h0, clkSrcSel});
    anyIrq <= 1'b0;
    wrap_up();
  end
endmodule
